//--- src/src_serial_receive_control.sv
// Purpose: Receive status and control register of a serial port, on AXI4-Lite.
// Assumes: Shift register logic sits outside; mode select comes from the transmit register.
// Notes: The receive buffer here is one word deep, read at its own offset.
// Notes on behaviour
// - Control register decoded at address 0x18.
// - Single receive in sync master, self clearing.
// - Async receiver runs while continuous enable set.
// - Clearing continuous enable stops async reception.
// - Mode select picks sync or async meaning.
//
// Local design decision: register access over AXI4-Lite.
module src_serial_receive_control
    import src_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sync_mode,
    input wire logic clock_master,
    input wire logic word_done,
    input wire logic [8:0] shift_word,
    input wire logic stop_bit_ok,
    output logic port_enable,
    output logic receiver_active,
    output logic single_receive_start,
    output logic nine_bit_mode,
    output logic irq
);
    // ****************************************
    // Mode inputs pass two flip-flops
    // ****************************************
    logic [1:0] sync_m_q;
    logic [1:0] master_m_q;
    logic [7:0] rsc_q;
    logic [8:0] rxbuf_q;
    logic full_q;
    logic [SRC_IRQ_WIDTH-1:0] ist_q;
    logic [SRC_IRQ_WIDTH-1:0] imask_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic single_receive_enable_pend_q;

    src_word_if word_bus ();

    src_word_capture u_capture
    (
        .mclk(mclk),
        .resetn(resetn),
        .word_done_in(word_done),
        .word_in(shift_word),
        .stop_ok_in(stop_bit_ok),
        .out(word_bus.source)
    );

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sync_m_q <= 2'h0;
            master_m_q <= 2'h0;
        end
        else
        begin
            sync_m_q <= {sync_m_q[0], sync_mode};
            master_m_q <= {master_m_q[0], clock_master};
        end
    end

    wire logic is_sync = sync_m_q[1];
    wire logic is_master = is_sync & master_m_q[1];
    wire logic serial_port_enable = rsc_q[SRC_SERIAL_PORT_ENABLE_BIT];
    wire logic continuous_receive_enable = rsc_q[SRC_CONTINUOUS_RECEIVE_ENABLE_BIT];
    wire logic single_receive_enable = rsc_q[SRC_SINGLE_RECEIVE_ENABLE_BIT];
    wire logic rx9 = rsc_q[SRC_RX9_BIT];
    wire logic address_detect_enable = rsc_q[SRC_ADDRESS_DETECT_ENABLE_BIT];

    // ****************************************
    // Write channel
    // ****************************************
    wire logic aw_have = aw_held_q | s_axi_awvalid;
    wire logic w_have = w_held_q | s_axi_wvalid;
    wire logic wr_fire = aw_have & w_have & ~bvalid_q;
    wire logic [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    wire logic wr_lane0 = wr_fire & wr_strb[0];
    wire logic wr_rsc = wr_lane0 & (wr_addr == SRC_RSC_OFFSET);
    wire logic wr_ist = wr_lane0 & (wr_addr == SRC_IRQ_STATUS_OFFSET);
    wire logic wr_imask = wr_lane0 & (wr_addr == SRC_IRQ_MASK_OFFSET);
    wire logic wr_known = (wr_addr == SRC_RSC_OFFSET) | (wr_addr == SRC_IRQ_STATUS_OFFSET)
        | (wr_addr == SRC_IRQ_MASK_OFFSET) | (wr_addr == SRC_MODE_OFFSET) | (wr_addr == SRC_RXDATA_OFFSET);

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ****************************************
    // Read channel
    // ****************************************
    wire logic rd_fire = s_axi_arvalid & ~rvalid_q;
    wire logic rd_buf = rd_fire & (s_axi_araddr == SRC_RXDATA_OFFSET);
    wire logic [7:0] rsc_view = {rsc_q[7:3], rsc_q[SRC_FRAMING_ERROR_FLAG_BIT], rsc_q[SRC_OVERRUN_ERROR_FLAG_BIT], rsc_q[SRC_NINTH_RECEIVED_BIT_BIT]};
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_known = 1'b1;
        case (s_axi_araddr)
            SRC_RSC_OFFSET: rd_mux = {24'h00_0000, rsc_view};
            SRC_MODE_OFFSET: rd_mux = {28'h000_0000, full_q, receiver_active, is_master, is_sync};
            SRC_IRQ_STATUS_OFFSET: rd_mux = {29'h0000_0000, ist_q};
            SRC_IRQ_MASK_OFFSET: rd_mux = {29'h0000_0000, imask_q};
            SRC_RXDATA_OFFSET: rd_mux = {24'h00_0000, rxbuf_q[7:0]};
            default: rd_known = 1'b0;
        endcase
    end

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= SRC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= SRC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready & ~wr_fire)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~wr_fire)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? SRC_RESP_OKAY : SRC_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? SRC_RESP_OKAY : SRC_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Receive control
    // ****************************************
    // Continuous receive overrides single receive in synchronous mode.
    assign receiver_active = serial_port_enable & (continuous_receive_enable | (is_master & single_receive_enable));
    // An address-detect frame with ninth bit clear is dropped, not loaded.
    wire logic addr_drop = ~is_sync & rx9 & address_detect_enable & ~word_bus.word[8];
    wire logic take = word_bus.valid & receiver_active & ~addr_drop;
    wire logic overrun = take & full_q;
    wire logic load = take & ~full_q & ~rsc_q[SRC_OVERRUN_ERROR_FLAG_BIT];
    wire logic continuous_receive_enable_clear = wr_rsc & ~wr_data[SRC_CONTINUOUS_RECEIVE_ENABLE_BIT];
    wire logic single_receive_enable_done = is_master & single_receive_enable & ~continuous_receive_enable & take;
    // A start with the port left off would have no receiver behind it, so it is not pulsed.
    wire logic single_receive_enable_set = wr_rsc & wr_data[SRC_SINGLE_RECEIVE_ENABLE_BIT] & wr_data[SRC_SERIAL_PORT_ENABLE_BIT] & is_master & ~single_receive_enable;
    logic [7:0] rsc_d;
    always_comb
    begin
        rsc_d = rsc_q;
        if (wr_rsc)
        begin
            rsc_d = (rsc_q & ~SRC_RSC_WMASK) | (wr_data[7:0] & SRC_RSC_WMASK);
        end
        if (single_receive_enable_done & ~single_receive_enable_set)
        begin
            rsc_d[SRC_SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
        end
        if (continuous_receive_enable_clear)
        begin
            rsc_d[SRC_OVERRUN_ERROR_FLAG_BIT] = 1'b0;
        end
        if (overrun)
        begin
            rsc_d[SRC_OVERRUN_ERROR_FLAG_BIT] = 1'b1;
        end
        if (load)
        begin
            rsc_d[SRC_FRAMING_ERROR_FLAG_BIT] = word_bus.frame_err;
            rsc_d[SRC_NINTH_RECEIVED_BIT_BIT] = word_bus.word[8];
        end
        if (!serial_port_enable)
        begin
            rsc_d[SRC_FRAMING_ERROR_FLAG_BIT] = 1'b0;
            rsc_d[SRC_OVERRUN_ERROR_FLAG_BIT] = 1'b0;
        end
    end

    logic [SRC_IRQ_WIDTH-1:0] ev;
    assign ev = {overrun, load & word_bus.frame_err, load};

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rsc_q <= SRC_RSC_RESET;
            rxbuf_q <= 9'h000;
            full_q <= 1'b0;
            ist_q <= '0;
            imask_q <= '0;
            single_receive_enable_pend_q <= 1'b0;
        end
        else
        begin
            rsc_q <= rsc_d;
            single_receive_enable_pend_q <= single_receive_enable_set;
            if (load)
            begin
                rxbuf_q <= word_bus.word;
            end
            // A new word loaded into an empty buffer wins over a read in the same cycle; one that meets a full buffer is an overrun.
            full_q <= load | (full_q & ~rd_buf);
            ist_q <= ev | (ist_q & ~(wr_ist ? wr_data[SRC_IRQ_WIDTH-1:0] : '0));
            if (wr_imask)
            begin
                imask_q <= wr_data[SRC_IRQ_WIDTH-1:0];
            end
        end
    end

    assign port_enable = serial_port_enable;
    assign nine_bit_mode = rx9;
    assign single_receive_start = single_receive_enable_pend_q;
    assign irq = |(ist_q & imask_q);
endmodule : src_serial_receive_control

//--- src/src_pkg.sv
// Purpose: Shared constants for the serial receive control block.
// Assumes: 32-bit AXI4-Lite register bus, 10 MHz mclk.
// Notes: Every offset lives here, with the field positions and reset value of the receive status and control register.
package src_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SRC_RSC_OFFSET = 8'h18;
    localparam logic [7:0] SRC_MODE_OFFSET = 8'h1C;
    localparam logic [7:0] SRC_IRQ_STATUS_OFFSET = 8'h20;
    localparam logic [7:0] SRC_IRQ_MASK_OFFSET = 8'h24;
    localparam logic [7:0] SRC_RXDATA_OFFSET = 8'h28;
    // ****************************************
    // Field positions of the receive status and control register
    // ****************************************
    localparam int SRC_SERIAL_PORT_ENABLE_BIT = 7;
    localparam int SRC_RX9_BIT = 6;
    localparam int SRC_SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int SRC_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int SRC_ADDRESS_DETECT_ENABLE_BIT = 3;
    localparam int SRC_FRAMING_ERROR_FLAG_BIT = 2;
    localparam int SRC_OVERRUN_ERROR_FLAG_BIT = 1;
    localparam int SRC_NINTH_RECEIVED_BIT_BIT = 0;
    localparam logic [7:0] SRC_RSC_WMASK = 8'hF8;
    localparam logic [7:0] SRC_RSC_RESET = 8'h00;
    // ****************************************
    // Interrupt status bits
    // ****************************************
    localparam int SRC_IRQ_RX_BIT = 0;
    localparam int SRC_IRQ_FRAMING_ERROR_FLAG_BIT = 1;
    localparam int SRC_IRQ_OVERRUN_ERROR_FLAG_BIT = 2;
    localparam int SRC_IRQ_WIDTH = 3;
    localparam logic [1:0] SRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SRC_RESP_SLVERR = 2'h2;
endpackage : src_pkg

//--- src/src_word_if.sv
// Purpose: Carries one received word from the capture stage to the register file.
// Assumes: Both ends run on mclk.
// Notes: A valid pulse lasts one cycle.
interface src_word_if;
    logic valid;
    logic [8:0] word;
    logic frame_err;
    modport source (output valid, output word, output frame_err);
    modport sink (input valid, input word, input frame_err);
endinterface : src_word_if

//--- src/src_word_capture.sv
// Purpose: Presents completed words from the shift stage as single-cycle events.
// Assumes: word_done_in is a synchronised level from the shift register logic.
// Notes: Rising edge of the done level marks a word.
module src_word_capture
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic word_done_in,
    input wire logic [8:0] word_in,
    input wire logic stop_ok_in,
    src_word_if.source out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic valid_q;
    logic [8:0] word_q;
    logic framing_error_flag_q;
    wire logic rise = s2_q & ~s3_q;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            valid_q <= 1'b0;
            word_q <= 9'h000;
            framing_error_flag_q <= 1'b0;
        end
        else
        begin
            s1_q <= word_done_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            valid_q <= rise;
            if (rise)
            begin
                // The shift stage holds word and stop bit steady while done is high.
                word_q <= word_in;
                framing_error_flag_q <= ~stop_ok_in;
            end
        end
    end

    assign out.valid = valid_q;
    assign out.word = word_q;
    assign out.frame_err = framing_error_flag_q;
endmodule : src_word_capture

//--- tb/src_shift_model.sv
// Purpose: Shift stage model that hands finished words to the receive control block.
// Assumes: One word at a time, on mclk.
// Notes: Word and stop flag change only while the done level is low.
module src_shift_model
(
    input wire logic mclk,
    output logic word_done = 1'b0,
    output logic [8:0] shift_word = 9'h1AA,
    output logic stop_bit_ok = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Word hand-over
    // ****************************************
    // Outside a word the lines show the inverse, so no stale value can pass for a fresh one.
    task send(input logic [8:0] w, input logic s);
        @(posedge mclk);
        shift_word <= w;
        stop_bit_ok <= s;
        word_done <= 1'b1;
        repeat (7) @(posedge mclk);
        word_done <= 1'b0;
        shift_word <= ~w;
        stop_bit_ok <= ~s;
        repeat (2) @(posedge mclk);
    endtask : send
endmodule : src_shift_model

//--- tb/src_serial_receive_control_checker.sv
// Purpose: Port assertions for the serial receive control block.
// Assumes: Single clock domain, synchronous active low reset.
// Notes: Attached by bind below.
module src_serial_receive_control_checker
    import src_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_enable,
    input wire logic receiver_active,
    input wire logic single_receive_start
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Bus and receive relations
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence wr_go;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_go;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    AST_WR_ANSWER: assert property (wr_go |=> s_axi_bvalid)
        else $error("write answer missing");
    AST_RD_ANSWER: assert property (rd_go |=> s_axi_rvalid)
        else $error("read answer missing");
    AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid)
        else $error("write answer dropped early");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    AST_NO_TAKE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == SRC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    AST_ACTIVE_EN: assert property (receiver_active |-> port_enable)
        else $error("receiver active with port off");
    AST_START_ONCE: assert property (single_receive_start |=> !single_receive_start && receiver_active)
        else $error("single receive start malformed");
endmodule : src_serial_receive_control_checker

bind src_serial_receive_control src_serial_receive_control_checker chk_u (.mclk(mclk), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_enable(port_enable), .receiver_active(receiver_active), .single_receive_start(single_receive_start));

//--- tb/src_serial_receive_control_bench.sv
// Purpose: Self-checking bench for the serial receive control block.
// Assumes: AXI4-Lite master tasks and a shift stage model on the word inputs.
// Notes: Mismatches print BAD lines and are counted.
module src_serial_receive_control_bench import src_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_mode = 1'b0, clock_master = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic port_enable, receiver_active, single_receive_start, nine_bit_mode, irq, word_done, stop_bit_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [8:0] shift_word;
    int fails = 0;
    int total_checks = 0;
    int starts = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk)
        if (single_receive_start === 1'b1)
            starts <= starts + 1;
    src_serial_receive_control dut_u (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sync_mode(sync_mode), .clock_master(clock_master),
        .word_done(word_done), .shift_word(shift_word), .stop_bit_ok(stop_bit_ok),
        .port_enable(port_enable), .receiver_active(receiver_active),
        .single_receive_start(single_receive_start), .nine_bit_mode(nine_bit_mode), .irq(irq));
    src_shift_model sh_u (.mclk(mclk), .word_done(word_done), .shift_word(shift_word), .stop_bit_ok(stop_bit_ok));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Port levels are looked at mid-cycle, once every update of the last edge has landed.
    task pchk(input logic [3:0] e);
        @(negedge mclk);
        chk({28'h0, irq, nine_bit_mode, receiver_active, port_enable}, {28'h0, e});
    endtask : pchk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge mclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        fails++;
        give_verdict();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tb;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge mclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
            if (tb)
            begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        fails++;
        give_verdict();
    endtask : rd
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rd(SRC_RSC_OFFSET);
        chk(d, {24'h0, SRC_RSC_RESET});
        rd(8'h40);
        chk({30'h0, r}, {30'h0, SRC_RESP_SLVERR});
        wr(8'h40, 32'hFF);
        chk({30'h0, r}, {30'h0, SRC_RESP_SLVERR});
        $display("test reset done");
        wr(SRC_RSC_OFFSET, 32'hD0);
        chk({30'h0, r}, {30'h0, SRC_RESP_OKAY});
        wr(SRC_IRQ_MASK_OFFSET, 32'h1);
        pchk(4'h7);
        rd(SRC_MODE_OFFSET);
        chk(d, 32'h4);
        sh_u.send(9'h155, 1'b1);
        pchk(4'hF);
        rd(SRC_RSC_OFFSET);
        chk(d, 32'hD1);
        rd(SRC_RXDATA_OFFSET);
        chk(d, 32'h55);
        wr(SRC_IRQ_STATUS_OFFSET, 32'h7);
        pchk(4'h7);
        $display("test async receive done");
        sh_u.send(9'h012, 1'b1);
        sh_u.send(9'h034, 1'b1);
        rd(SRC_RSC_OFFSET);
        chk(d & 32'h2, 32'h2);
        wr(SRC_RSC_OFFSET, 32'hC0);
        rd(SRC_RSC_OFFSET);
        chk(d & 32'h12, 32'h0);
        pchk(4'hD);
        rd(SRC_RXDATA_OFFSET);
        chk(d, 32'h12);
        wr(SRC_IRQ_STATUS_OFFSET, 32'h7);
        sh_u.send(9'h056, 1'b1);
        rd(SRC_IRQ_STATUS_OFFSET);
        chk(d, 32'h0);
        $display("test overrun done");
        wr(SRC_RSC_OFFSET, 32'hD0);
        sh_u.send(9'h0AB, 1'b0);
        rd(SRC_RSC_OFFSET);
        chk(d, 32'hD4);
        rd(SRC_IRQ_STATUS_OFFSET);
        chk(d, 32'h3);
        rd(SRC_RXDATA_OFFSET);
        chk(d, 32'hAB);
        wr(SRC_IRQ_STATUS_OFFSET, 32'h7);
        wr(SRC_RSC_OFFSET, 32'hD8);
        sh_u.send(9'h0CD, 1'b1);
        rd(SRC_IRQ_STATUS_OFFSET);
        chk(d, 32'h0);
        sh_u.send(9'h1EF, 1'b1);
        rd(SRC_RSC_OFFSET);
        chk(d, 32'hD9);
        rd(SRC_RXDATA_OFFSET);
        chk(d, 32'hEF);
        wr(SRC_IRQ_STATUS_OFFSET, 32'h7);
        $display("test framing and address detect done");
        wr(SRC_RSC_OFFSET, 32'hA0);
        pchk(4'h1);
        @(posedge mclk);
        sync_mode <= 1'b1;
        clock_master <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(SRC_RSC_OFFSET, 32'h80);
        wr(SRC_RSC_OFFSET, 32'hA0);
        pchk(4'h3);
        chk(starts, 1);
        rd(SRC_MODE_OFFSET);
        chk(d, 32'h7);
        sh_u.send(9'h077, 1'b1);
        rd(SRC_RSC_OFFSET);
        chk(d & 32'h20, 32'h0);
        pchk(4'h9);
        $display("test sync single receive done");
        give_verdict();
    end
endmodule : src_serial_receive_control_bench
